/* core/mms_pkg.sv */
// Constants, index map and status carriers of the MAC statistics block.
// Assumes frame status arrives from MAC logic on the same clock.
//
// How it works
// - Good rx: error-free, 64 to max bytes
// - Length counts destination address through FCS
// - Bad rx: CRC, FIFO overflow or length field error, or length out of range
// - Error control character marks rx frame bad
// - Count good received unicast frames
// - Count good received multicast, pause excluded
// - Count good received broadcast frames
// - Count good tx unicast, multicast, broadcast separately
// - Count rx overflow, CRC, length, terminated errors
// - Count tx FIFO overflow or underflow frames
// - Count drops from persistent rx overflow
// - Sum received bytes, good and bad
// - Count every received frame
// - Count received frames under 64 bytes
// - Count frames longer than programmed maximum
// - Count frames exactly 64 bytes long
// - Histogram bins 65 up to 1518 bytes
// - Bin 1519 bytes up to programmed maximum
// - Count oversize frames with CRC error
// - Count undersize frames with CRC error
// - Clear command wipes counters, then self-clears
// - Lower word read caches upper word
package mms_pkg;

    // -------------------------------------------------------------------
    // Widths and length thresholds
    // -------------------------------------------------------------------
    localparam int          MMS_LEN_W     = 16;
    localparam int          MMS_SEL_W     = 5;
    localparam int          MMS_WORD_W    = 32;
    localparam int          MMS_NUM_CNT   = 22;
    localparam logic [15:0] MMS_MIN_LEN   = 16'h0040; // 64
    localparam logic [15:0] MMS_BIN_127   = 16'h007f;
    localparam logic [15:0] MMS_BIN_255   = 16'h00ff;
    localparam logic [15:0] MMS_BIN_511   = 16'h01ff;
    localparam logic [15:0] MMS_BIN_1023  = 16'h03ff;
    localparam logic [15:0] MMS_BIN_1518  = 16'h05ee;
    localparam logic [63:0] MMS_CNT_RST   = 64'h0;

    // -------------------------------------------------------------------
    // Counter index map on the read port
    // -------------------------------------------------------------------
    localparam logic [4:0] MMS_IDX_RX_UCAST  = 5'h00;
    localparam logic [4:0] MMS_IDX_RX_MCAST  = 5'h01;
    localparam logic [4:0] MMS_IDX_RX_BCAST  = 5'h02;
    localparam logic [4:0] MMS_IDX_TX_UCAST  = 5'h03;
    localparam logic [4:0] MMS_IDX_TX_MCAST  = 5'h04;
    localparam logic [4:0] MMS_IDX_TX_BCAST  = 5'h05;
    localparam logic [4:0] MMS_IDX_RX_ERR    = 5'h06;
    localparam logic [4:0] MMS_IDX_TX_ERR    = 5'h07;
    localparam logic [4:0] MMS_IDX_DROP      = 5'h08;
    localparam logic [4:0] MMS_IDX_OCTETS    = 5'h09;
    localparam logic [4:0] MMS_IDX_PKTS      = 5'h0a;
    localparam logic [4:0] MMS_IDX_UNDER     = 5'h0b;
    localparam logic [4:0] MMS_IDX_OVER      = 5'h0c;
    localparam logic [4:0] MMS_IDX_H64       = 5'h0d;
    localparam logic [4:0] MMS_IDX_H65       = 5'h0e;
    localparam logic [4:0] MMS_IDX_H128      = 5'h0f;
    localparam logic [4:0] MMS_IDX_H256      = 5'h10;
    localparam logic [4:0] MMS_IDX_H512      = 5'h11;
    localparam logic [4:0] MMS_IDX_H1024     = 5'h12;
    localparam logic [4:0] MMS_IDX_H1519     = 5'h13;
    localparam logic [4:0] MMS_IDX_JABBER    = 5'h14;
    localparam logic [4:0] MMS_IDX_FRAGMENT  = 5'h15;

    // -------------------------------------------------------------------
    // Status carriers
    // -------------------------------------------------------------------
    typedef struct packed {
        logic                 valid;    // One-cycle end-of-frame strobe
        logic [MMS_LEN_W-1:0] length;   // Destination address to FCS
        logic [47:0]          dest;     // Destination address
        logic                 crc_err;
        logic                 ctrl_err; // Error character inside frame
        logic                 fifo_ovf;
        logic                 len_err;  // Length field mismatch
        logic                 pause;    // Pause control frame
        logic                 drop;     // Independent drop-event strobe
    } mms_rx_stat_t;

    typedef struct packed {
        logic                 valid;
        logic [47:0]          dest;
        logic                 fifo_ovf;
        logic                 fifo_unf;
    } mms_tx_stat_t;

    typedef enum logic {
        MMS_CLR_IDLE,
        MMS_CLR_WALK
    } mms_clr_state_t;

endpackage

/* core/mms_stats.sv */
// Statistics counters of the 10 Gb/s MAC with a word-wide read port.
// Assumes rx_stat, tx_stat and max_frame_len come from clk-domain logic.
`timescale 1ns/10ps
module mms_stats #(
    parameter int CNT_W = 64
) (
    // Clock and reset
    input  wire logic                               clk,
    input  wire logic                               nrst,
    // Frame status from the MAC paths
    input  wire mms_pkg::mms_rx_stat_t              rx_stat,
    input  wire mms_pkg::mms_tx_stat_t              tx_stat,
    input  wire logic [mms_pkg::MMS_LEN_W-1:0]      max_frame_len,
    // Clear command
    input  wire logic                               counter_clear_command,
    output logic                                    counter_clear_busy,
    // Counter read port
    input  wire logic                               rd_req,
    input  wire logic [mms_pkg::MMS_SEL_W-1:0]      rd_sel,
    input  wire logic                               rd_upper,
    output logic [mms_pkg::MMS_WORD_W-1:0]          rd_data,
    output logic                                    rd_valid
);
    import mms_pkg::*;

    // -------------------------------------------------------------------
    // Elaboration checks
    // -------------------------------------------------------------------
    generate
        if (CNT_W <= MMS_WORD_W || CNT_W > 2 * MMS_WORD_W)
        begin : g_bad_width
            $error("CNT_W must lie in 33 to 64");
        end
    endgenerate

    // -------------------------------------------------------------------
    // Reset release
    // -------------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    // Two-stage release of the asynchronous reset
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // -------------------------------------------------------------------
    // Frame classification
    // -------------------------------------------------------------------
    logic                   rx_bcast;
    logic                   rx_mcast;
    logic                   rx_ucast;
    logic                   tx_bcast;
    logic                   tx_mcast;
    logic                   rx_short;
    logic                   rx_long;
    logic                   rx_good;
    logic                   rx_bad_any;
    logic                   tx_good;
    logic [MMS_LEN_W-1:0]   len;
    logic [MMS_NUM_CNT-1:0] inc;

    // Address kind: first octet's low bit marks group addresses
    assign rx_bcast = &rx_stat.dest;
    assign rx_mcast = rx_stat.dest[40] & ~rx_bcast;
    assign rx_ucast = ~rx_stat.dest[40];
    assign tx_bcast = &tx_stat.dest;
    assign tx_mcast = tx_stat.dest[40] & ~tx_bcast;

    // Length already spans destination address to FCS inclusive
    assign len      = rx_stat.length;
    assign rx_short = len < MMS_MIN_LEN;
    assign rx_long  = len > max_frame_len;

    // Good only when clean and within the valid length window
    assign rx_good  = ~rx_stat.crc_err & ~rx_stat.ctrl_err
                    & ~rx_stat.fifo_ovf & ~rx_stat.len_err
                    & ~rx_short & ~rx_long;
    assign rx_bad_any = rx_stat.fifo_ovf | rx_stat.crc_err
                      | rx_stat.len_err | rx_short | rx_long
                      | rx_stat.ctrl_err;
    assign tx_good  = ~tx_stat.fifo_ovf & ~tx_stat.fifo_unf;

    // Increment requests, taken on the rx or tx end-of-frame strobe; drop on its own strobe
    always_comb
    begin
        inc = '0;
        if (rx_stat.valid)
        begin
            inc[MMS_IDX_RX_UCAST] = rx_good & rx_ucast;
            inc[MMS_IDX_RX_MCAST] = rx_good & rx_mcast
                                  & ~rx_stat.pause;
            inc[MMS_IDX_RX_BCAST] = rx_good & rx_bcast;
            inc[MMS_IDX_RX_ERR]   = rx_bad_any;
            inc[MMS_IDX_OCTETS]   = 1'b1;
            inc[MMS_IDX_PKTS]     = 1'b1;
            inc[MMS_IDX_UNDER]    = rx_short;
            inc[MMS_IDX_OVER]     = rx_long;
            inc[MMS_IDX_H64]      = len == MMS_MIN_LEN;
            inc[MMS_IDX_H65]      = len > MMS_MIN_LEN
                                  && len <= MMS_BIN_127;
            inc[MMS_IDX_H128]     = len > MMS_BIN_127
                                  && len <= MMS_BIN_255;
            inc[MMS_IDX_H256]     = len > MMS_BIN_255
                                  && len <= MMS_BIN_511;
            inc[MMS_IDX_H512]     = len > MMS_BIN_511
                                  && len <= MMS_BIN_1023;
            inc[MMS_IDX_H1024]    = len > MMS_BIN_1023
                                  && len <= MMS_BIN_1518;
            inc[MMS_IDX_H1519]    = len > MMS_BIN_1518
                                  && !rx_long;
            inc[MMS_IDX_JABBER]   = rx_long
                                  & rx_stat.crc_err;
            inc[MMS_IDX_FRAGMENT] = rx_short
                                  & rx_stat.crc_err;
        end
        if (tx_stat.valid)
        begin
            inc[MMS_IDX_TX_UCAST] = tx_good
                                  & ~tx_stat.dest[40];
            inc[MMS_IDX_TX_MCAST] = tx_good & tx_mcast;
            inc[MMS_IDX_TX_BCAST] = tx_good & tx_bcast;
            inc[MMS_IDX_TX_ERR]   = ~tx_good;
        end
        inc[MMS_IDX_DROP] = rx_stat.drop;
    end

    // -------------------------------------------------------------------
    // Clear sequencer
    // -------------------------------------------------------------------
    mms_clr_state_t         clr_state;
    mms_clr_state_t         next_clr_state;
    logic [MMS_SEL_W-1:0]   clr_idx;
    logic [MMS_SEL_W-1:0]   next_clr_idx;
    logic                   next_counter_clear_busy;

    // Walks every counter once; the busy flag drops after the last
    always_comb
    begin
        next_clr_state = clr_state;
        next_clr_idx   = clr_idx;
        case (clr_state)
            MMS_CLR_IDLE:
            begin
                next_clr_idx = '0;
                if (counter_clear_command)
                begin
                    next_clr_state = MMS_CLR_WALK;
                end
            end
            MMS_CLR_WALK:
            begin
                if (clr_idx == MMS_SEL_W'(MMS_NUM_CNT - 1))
                begin
                    next_clr_state = MMS_CLR_IDLE;
                    next_clr_idx   = '0;
                end
                else
                begin
                    next_clr_idx = clr_idx + 1'b1;
                end
            end
            default:
            begin
                next_clr_state = MMS_CLR_IDLE;
                next_clr_idx   = '0;
            end
        endcase
        next_counter_clear_busy = next_clr_state == MMS_CLR_WALK;
    end

    // Clear sequencer state
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clr_state          <= MMS_CLR_IDLE;
            clr_idx            <= '0;
            counter_clear_busy <= 1'b0;
        end
        else
        begin
            clr_state          <= next_clr_state;
            clr_idx            <= next_clr_idx;
            counter_clear_busy <= next_counter_clear_busy;
        end
    end

    // -------------------------------------------------------------------
    // Counter array
    // -------------------------------------------------------------------
    logic [CNT_W-1:0] cnt      [MMS_NUM_CNT];
    logic [CNT_W-1:0] next_cnt [MMS_NUM_CNT];
    logic [CNT_W-1:0] octet_step;

    assign octet_step = {{(CNT_W - MMS_LEN_W){1'b0}}, len};

    generate
        for (genvar i = 0; i < MMS_NUM_CNT; i++)
        begin : g_cnt
            logic [CNT_W-1:0] step;

            // Octet counter adds the frame length, others add one
            if (i == int'(MMS_IDX_OCTETS))
            begin : g_oct
                assign step = octet_step;
            end
            else
            begin : g_one
                assign step = {{(CNT_W - 1){1'b0}}, 1'b1};
            end

            // Clearing wins over a coincident increment
            always_comb
            begin
                if (clr_state == MMS_CLR_WALK
                    && clr_idx == MMS_SEL_W'(i))
                begin
                    next_cnt[i] = '0;
                end
                else if (inc[i])
                begin
                    next_cnt[i] = cnt[i] + step;
                end
                else
                begin
                    next_cnt[i] = cnt[i];
                end
            end

            // Counter storage
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    cnt[i] <= MMS_CNT_RST[CNT_W-1:0];
                end
                else
                begin
                    cnt[i] <= next_cnt[i];
                end
            end
        end
    endgenerate

    // -------------------------------------------------------------------
    // Read port with upper-word cache
    // -------------------------------------------------------------------
    logic [MMS_WORD_W-1:0] cache;
    logic [MMS_WORD_W-1:0] next_cache;
    logic                  cache_ok;
    logic                  next_cache_ok;
    logic [MMS_SEL_W-1:0]  cache_sel;
    logic [MMS_SEL_W-1:0]  next_cache_sel;
    logic [MMS_WORD_W-1:0] next_rd_data;
    logic                  next_rd_valid;

    // Lower read snapshots the upper word; a matching upper read uses it
    always_comb
    begin
        next_cache     = cache;
        next_cache_ok  = cache_ok;
        next_cache_sel = cache_sel;
        next_rd_data   = '0;
        next_rd_valid  = rd_req;
        if (rd_req && rd_sel < MMS_SEL_W'(MMS_NUM_CNT))
        begin
            if (!rd_upper)
            begin
                next_rd_data   = cnt[rd_sel][MMS_WORD_W-1:0];
                next_cache     = MMS_WORD_W'(cnt[rd_sel] >> MMS_WORD_W);
                next_cache_ok  = 1'b1;
                next_cache_sel = rd_sel;
            end
            else if (cache_ok && cache_sel == rd_sel)
            begin
                next_rd_data  = cache;
                next_cache_ok = 1'b0;
            end
            else
            begin
                next_rd_data  = MMS_WORD_W'(cnt[rd_sel] >> MMS_WORD_W);
                next_cache_ok = 1'b0;
            end
        end
        else if (rd_req)
        begin
            next_cache_ok = 1'b0;
        end
    end

    // Read port registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cache     <= '0;
            cache_ok  <= 1'b0;
            cache_sel <= '0;
            rd_data   <= '0;
            rd_valid  <= 1'b0;
        end
        else
        begin
            cache     <= next_cache;
            cache_ok  <= next_cache_ok;
            cache_sel <= next_cache_sel;
            rd_data   <= next_rd_data;
            rd_valid  <= next_rd_valid;
        end
    end

endmodule

/* testbench/mms_mac_model.sv */
// Model of the MAC receive and transmit paths that report frame status.
// Assumes the bench calls its tasks from a process synchronous to clk.
`timescale 1ns/10ps
module mms_mac_model
    import mms_pkg::*;
(
    // Clock
    input  wire logic         clk,
    // Frame status towards the counters
    output mms_rx_stat_t      rx_stat,
    output mms_tx_stat_t      tx_stat
);
    // ------------------------------------------------------------------
    // Status drivers
    // ------------------------------------------------------------------
    // Idle status at time zero
    initial
    begin
        rx_stat = '0;
        tx_stat = '0;
    end

    // One end-of-frame strobe, then fields released to inverted values
    task automatic send_rx(input logic [15:0] len, input logic [47:0] da,
                           input logic [4:0] f);
        mms_rx_stat_t fr;
        fr = '{1'b1, len, da, f[4], f[3], f[2], f[1], f[0], 1'b0};
        @(posedge clk);
        rx_stat <= fr;
        fr = ~fr;
        fr.valid = 1'b0;
        fr.drop = 1'b0;
        @(posedge clk);
        rx_stat <= fr;
    endtask

    // Drop event pulse outside any frame strobe
    task automatic pulse_drop();
        @(posedge clk);
        rx_stat.drop <= 1'b1;
        @(posedge clk);
        rx_stat.drop <= 1'b0;
    endtask

    // Transmit status strobe, fields released afterwards
    task automatic send_tx(input logic [47:0] da, input logic ovf,
                           input logic unf);
        mms_tx_stat_t ft;
        ft = '{1'b1, da, ovf, unf};
        @(posedge clk);
        tx_stat <= ft;
        ft = ~ft;
        ft.valid = 1'b0;
        @(posedge clk);
        tx_stat <= ft;
    endtask
endmodule

/* testbench/mms_stats_checker.sv */
// Concurrent checks on the read port and clear walk of the counters.
// Assumes the single clk domain and the nrst pin of the top module.
`timescale 1ns/10ps
module mms_checker
    import mms_pkg::*;
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         nrst,
    // Frame status
    input  wire mms_rx_stat_t rx_stat,
    input  wire mms_tx_stat_t tx_stat,
    // Clear command
    input  wire logic         counter_clear_command,
    input  wire logic         counter_clear_busy,
    // Read port
    input  wire logic         rd_req,
    input  wire logic [4:0]   rd_sel,
    input  wire logic         rd_upper,
    input  wire logic [31:0]  rd_data,
    input  wire logic         rd_valid
);
    logic       quiet;
    logic [4:0] walk_cnt;
    logic [4:0] next_walk_cnt;

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    // ------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------
    // No event that could move a counter this cycle
    assign quiet = !rx_stat.valid && !rx_stat.drop && !tx_stat.valid
                   && !counter_clear_busy;

    // Busy cycles of the current clear walk
    always_comb
        next_walk_cnt = counter_clear_busy ? walk_cnt + 5'h01 : 5'h00;

    // Walk cycle counter, cleared by the pin reset
    always_ff @(posedge clk or negedge nrst)
        if (!nrst)
            walk_cnt <= 5'h00;
        else
            walk_cnt <= next_walk_cnt;

    // ------------------------------------------------------------------
    // Sequences and assertions
    // ------------------------------------------------------------------
    sequence s_clr_req;
        counter_clear_command && !counter_clear_busy;
    endsequence

    sequence s_lower_twice;
        rd_req && !rd_upper && quiet
        ##1 rd_req && !rd_upper && $stable(rd_sel);
    endsequence

    chk_read_answer: assert property (rd_req |=> rd_valid)
        else $error("read request not answered next cycle");
    chk_read_single: assert property (
        !rd_req |=> !rd_valid && rd_data == 32'h0)
        else $error("read data or valid without a request");
    chk_bad_index: assert property (
        rd_req && rd_sel >= 5'h16 |=> rd_data == 32'h0)
        else $error("unmapped counter index returned data");
    chk_read_stable: assert property (
        s_lower_twice |=> $stable(rd_data))
        else $error("counter moved without any event");
    chk_clear_start: assert property (s_clr_req |=> counter_clear_busy)
        else $error("clear command did not start the walk");
    chk_clear_hold: assert property (
        s_clr_req |=> counter_clear_busy[*8])
        else $error("clear walk ended early");
    chk_clear_len: assert property (
        $fell(counter_clear_busy) |-> walk_cnt == 5'h16)
        else $error("clear walk length wrong");
    chk_clear_bound: assert property (
        counter_clear_busy |-> walk_cnt < 5'h16)
        else $error("clear walk overran");
endmodule

bind mms_stats mms_checker u_chk (
    .clk(clk), .nrst(nrst), .rx_stat(rx_stat), .tx_stat(tx_stat),
    .counter_clear_command(counter_clear_command),
    .counter_clear_busy(counter_clear_busy), .rd_req(rd_req),
    .rd_sel(rd_sel), .rd_upper(rd_upper), .rd_data(rd_data),
    .rd_valid(rd_valid)
);

/* testbench/tb_top.sv */
// Self-checking bench for the MAC statistics counters.
// Assumes the MAC status model and the bound checker.
`timescale 1ns/10ps
module tb_top;
    import mms_pkg::*;
    logic         clk;
    logic         nrst;
    logic         cmd;
    logic         busy;
    logic         rd_req;
    logic [4:0]   rd_sel;
    logic         rd_upper;
    logic [31:0]  rd_data;
    logic         rd_valid;
    logic [15:0]  max_len;
    mms_rx_stat_t rx_stat;
    mms_tx_stat_t tx_stat;
    logic [63:0]  exp_cnt [MMS_NUM_CNT];
    int           errors;
    int           check_count;
    localparam logic [47:0] UC = 48'h0200_0000_0001;
    localparam logic [47:0] MC = 48'h0100_5e00_0001;
    localparam logic [47:0] BC = 48'hffff_ffff_ffff;

    mms_stats DUT (.clk(clk), .nrst(nrst), .rx_stat(rx_stat),
        .tx_stat(tx_stat), .max_frame_len(max_len),
        .counter_clear_command(cmd), .counter_clear_busy(busy),
        .rd_req(rd_req), .rd_sel(rd_sel), .rd_upper(rd_upper),
        .rd_data(rd_data), .rd_valid(rd_valid));
    mms_mac_model MAC (.clk(clk), .rx_stat(rx_stat), .tx_stat(tx_stat));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    // Single compare point, counts checks and mismatches
    task automatic chk(input string nm, input logic [63:0] seen, exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Expected counter bump when the condition holds
    task automatic inc(input logic [4:0] i, input logic c);
        exp_cnt[i] += {63'h0, c};
    endtask

    // One read, answer sampled one cycle after it is taken
    task automatic rd(input logic [4:0] s, input logic u,
                      output logic [31:0] d);
        @(posedge clk);
        rd_req <= 1'b1;
        rd_sel <= s;
        rd_upper <= u;
        @(posedge clk);
        rd_req <= 1'b0;
        #1;
        d = rd_data;
        chk("rd_valid", {63'h0, rd_valid}, 64'h1);
    endtask

    // Lower then upper read of every counter against the model
    task automatic check_all(input string t);
        logic [31:0] lo;
        logic [31:0] hi;
        for (int i = 0; i < MMS_NUM_CNT; i++)
        begin
            rd(5'(i), 1'b0, lo);
            rd(5'(i), 1'b1, hi);
            chk($sformatf("cnt%0d", i), {hi, lo}, exp_cnt[i]);
        end
        $display("test %s done", t);
    endtask

    // Received frame and its expected counter effects
    task automatic rx(input logic [15:0] n, input logic [47:0] da,
                      input logic [4:0] f);
        logic under;
        logic over;
        logic good;
        under = n < MMS_MIN_LEN;
        over = n > max_len;
        good = !(|f[4:1]) && !under && !over;
        MAC.send_rx(n, da, f);
        inc(MMS_IDX_PKTS, 1'b1);
        exp_cnt[MMS_IDX_OCTETS] += {48'h0, n};
        inc(MMS_IDX_RX_UCAST, good && !da[40]);
        inc(MMS_IDX_RX_MCAST, good && da[40] && !(&da) && !f[0]);
        inc(MMS_IDX_RX_BCAST, good && (&da));
        inc(MMS_IDX_RX_ERR, !good);
        inc(MMS_IDX_UNDER, under);
        inc(MMS_IDX_OVER, over);
        inc(MMS_IDX_H64, n == MMS_MIN_LEN);
        inc(MMS_IDX_H65, n > MMS_MIN_LEN && n <= MMS_BIN_127);
        inc(MMS_IDX_H128, n > MMS_BIN_127 && n <= MMS_BIN_255);
        inc(MMS_IDX_H256, n > MMS_BIN_255 && n <= MMS_BIN_511);
        inc(MMS_IDX_H512, n > MMS_BIN_511 && n <= MMS_BIN_1023);
        inc(MMS_IDX_H1024, n > MMS_BIN_1023 && n <= MMS_BIN_1518);
        inc(MMS_IDX_H1519, n > MMS_BIN_1518 && !over);
        inc(MMS_IDX_JABBER, over && f[4]);
        inc(MMS_IDX_FRAGMENT, under && f[4]);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_good();
        rx(16'h0040, UC, 5'h00);
        check_all("good_unicast");
    endtask

    task automatic t_rx_mix();
        logic [15:0] ln [23] = '{40, 63, 65, 127, 128, 255, 256, 511, 512,
            1023, 1024, 1518, 1519, 1600, 1601, 1700, 100, 100, 200, 300,
            300, 400, 64};
        logic [4:0] fl [23] = '{0, 5'h10, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0,
            0, 0, 5'h10, 0, 5'h01, 0, 5'h08, 5'h04, 5'h02, 5'h10};
        for (int i = 0; i < 23; i++)
            rx(ln[i], (i == 18) ? BC : (i == 16 || i > 21) ? MC : UC, fl[i]);
        rx(16'h0064, MC, 5'h01);
        MAC.pulse_drop();
        inc(MMS_IDX_DROP, 1'b1);
        check_all("rx_mix");
    endtask

    task automatic t_tx();
        logic [47:0] da [5] = '{UC, MC, BC, UC, MC};
        for (int i = 0; i < 5; i++)
        begin
            MAC.send_tx(da[i], i == 3, i == 4);
            inc(MMS_IDX_TX_UCAST, i == 0);
            inc(MMS_IDX_TX_MCAST, i == 1);
            inc(MMS_IDX_TX_BCAST, i == 2);
            inc(MMS_IDX_TX_ERR, i > 2);
        end
        check_all("tx");
    endtask

    // Command held two cycles: a repeat while busy is ignored
    task automatic t_clear();
        int n;
        n = 0;
        for (int k = 0; k < 30; k++)
        begin
            @(posedge clk);
            cmd <= (k < 2);
            #1;
            n += int'(busy === 1'b1);
        end
        chk("busy_cycles", 64'(n), 64'd22);
        foreach (exp_cnt[i])
            exp_cnt[i] = 64'h0;
        check_all("clear");
    endtask

    // Two lower reads, then the cached upper word, then unmapped reads
    task automatic t_read_pair();
        logic [31:0] d;
        rx(16'h03e8, UC, 5'h00);
        @(posedge clk);
        rd_req <= 1'b1;
        rd_sel <= MMS_IDX_OCTETS;
        rd_upper <= 1'b0;
        @(posedge clk);
        #1;
        chk("lower1", {32'h0, rd_data}, 64'h3e8);
        @(posedge clk);
        rd_upper <= 1'b1;
        #1;
        chk("lower2", {32'h0, rd_data}, 64'h3e8);
        @(posedge clk);
        rd_req <= 1'b0;
        #1;
        chk("upper", {32'h0, rd_data}, 64'h0);
        @(posedge clk);
        #1;
        chk("valid_low", {63'h0, rd_valid}, 64'h0);
        rd(5'h16, 1'b0, d);
        chk("unmapped_lo", {32'h0, d}, 64'h0);
        rd(5'h1f, 1'b1, d);
        chk("unmapped_hi", {32'h0, d}, 64'h0);
        $display("test read_pair done");
    endtask

    // Counts line, verdict and end of run
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------------
    // Free-running 40 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Watchdog against a hung scenario
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        end_sim();
    end

    // Reset, then the scenarios in order
    initial
    begin
        nrst = 1'b0;
        cmd = 1'b0;
        rd_req = 1'b0;
        rd_sel = 5'h00;
        rd_upper = 1'b0;
        max_len = 16'h0640;
        errors = 0;
        check_count = 0;
        foreach (exp_cnt[i])
            exp_cnt[i] = 64'h0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        t_good();
        t_rx_mix();
        t_tx();
        t_clear();
        t_read_pair();
        end_sim();
    end
endmodule
